/* File: common/eep_pkg.sv */
/*
 * Shared constants and types for the two-wire serial EEPROM slave.
 * Assumes a 40 MHz reference clock; the link clock is the serial clock.
 */
package eep_pkg;

    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned PROG_TIME_MS = 10;
    // longest time: integer division rounds down
    localparam int unsigned PROG_CYCLES  = (CLK_HZ / 1000) * PROG_TIME_MS;
    localparam int unsigned TIMER_W      = 20;

    localparam int unsigned ROW_BITS  = 5;
    localparam int unsigned ROW_BYTES = 32;
    localparam int unsigned AW_64K    = 13;
    localparam int unsigned AW_32K    = 12;

    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_ACK  = 4'h8;
    localparam logic [3:0] CNT_RST  = 4'h0;
    localparam logic [7:0] ERASED   = 8'hFF;
    // pin samples after reset: clock and data idle high, no false edge
    localparam logic [5:0] PINS_IDLE = 6'h03;
    // device type code; value arbitrary
    localparam logic [3:0] DEV_TYPE = 4'hA;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEV  = 7'h02,
        ST_AHI  = 7'h04,
        ST_ALO  = 7'h08,
        ST_WDAT = 7'h10,
        ST_RDAT = 7'h20,
        ST_PROG = 7'h40
    } eep_state_e;

    typedef struct packed {
        logic       wp;
        logic [2:0] cs;
        logic       sda;
        logic       scl;
    } eep_pins_s;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } eep_wr_s;

endpackage

/* File: rtl/eep_array.sv */
/*
 * Byte array of the EEPROM, held in flip-flops.
 * Assumes one write port driven by the slave's commit walk.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_array #(
    parameter int unsigned AW = 13
) (
    input  wire logic           i_ref_clk,
    input  wire logic           i_rst_b,
    input  wire logic           i_ce,
    input  wire eep_pkg::eep_wr_s i_wr,
    input  wire logic [15:0]    i_raddr,
    output logic      [7:0]     o_rdata
);

    if (AW < 1 || AW > 16)
    begin : g_chk
        $error("eep_array: AW out of range");
    end

    logic [7:0] mem_ff [2**AW];

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int i = 0; i < 2**AW; i++)
            begin
                mem_ff[i] <= eep_pkg::ERASED;
            end
        end
        else if (i_ce && i_wr.we)
        begin
            mem_ff[i_wr.addr[AW-1:0]] <= i_wr.data;
        end
    end

    assign o_rdata = mem_ff[i_raddr[AW-1:0]];

endmodule
`default_nettype wire

/* File: rtl/eep_i2c_slave.sv */
/*
 * Slave command logic of a two-wire serial byte EEPROM.
 * Assumes the master drives the serial clock and an external pull-up
 * resolves the open-drain data line from o_sda_oe.
 */
// Overview of operation
// - address arrives high byte then low byte
// - 64-kbit part ignores address bits 15..13
// - 32-kbit part ignores address bits 15..12
// - write select acked, two address bytes follow
// - protect seen in header: data unacked, unwritten
// - byte write: one data byte, ack, stop
// - page write takes 1..32 bytes, one cycle
// - page write increments low five address bits
// - only stop in tenth slot starts programming
// - bus ignored while programming runs
// - program cycle ends within 10 ms
// - select unacked while busy, acked afterwards
// - acked poll byte starts the next command
// - array reads all ones before writes
// - address counter increments per byte read
// - current read: ack, send byte at counter
// - random read: dummy write then read select
// - select byte: type, chip select, direction
// - protect still acks select and address bytes
// - stop after read returns to standby
// - master nack in ack slot ends reading
`timescale 1ns/1ps
`default_nettype none
module eep_i2c_slave #(
    parameter int unsigned MEM_AW        = eep_pkg::AW_64K,
    parameter int unsigned P_PROG_CYCLES = eep_pkg::PROG_CYCLES,
    parameter logic [3:0]  P_DEV_TYPE    = eep_pkg::DEV_TYPE
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    input  wire logic       i_scl,
    input  wire logic       i_sda_i,
    output logic            o_sda_o,
    output logic            o_sda_oe,
    input  wire logic       i_write_protect_in,
    input  wire logic [2:0] i_chip_select_pins,
    output logic            o_busy
);

    localparam int unsigned RB = eep_pkg::ROW_BITS;
    localparam int unsigned TW = eep_pkg::TIMER_W;
    localparam logic [TW-1:0] TIMER_LAST = TW'(P_PROG_CYCLES - 1);
    localparam logic [TW-1:0] TIMER_ROW  = TW'(eep_pkg::ROW_BYTES);

    if ((MEM_AW != eep_pkg::AW_64K && MEM_AW != eep_pkg::AW_32K)
        || P_PROG_CYCLES <= eep_pkg::ROW_BYTES
        || P_PROG_CYCLES >= (2**TW))
    begin : g_chk
        $error("eep_i2c_slave: unsupported parameters");
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    function automatic logic [MEM_AW-1:0] row_inc(
        input logic [MEM_AW-1:0] a
    );
        row_inc = {a[MEM_AW-1:RB], RB'(a[RB-1:0] + 1'b1)};
    endfunction

    // link domain: the only logic on the serial clock
    logic [7:0] link_shift_ff;

    always_ff @(posedge i_scl or negedge i_rst_b)
    begin
        if (!i_rst_b)
            link_shift_ff <= 8'h00;
        else
            link_shift_ff <= {link_shift_ff[6:0], i_sda_i};
    end

    // pin sampling: three stages, level moves when last two agree
    eep_pkg::eep_pins_s pins_in;
    eep_pkg::eep_pins_s meta_ff;
    eep_pkg::eep_pins_s syn_a_ff;
    eep_pkg::eep_pins_s syn_b_ff;
    eep_pkg::eep_pins_s pins_ff;
    eep_pkg::eep_pins_s nxt_pins;

    assign pins_in = {i_write_protect_in, i_chip_select_pins,
                      i_sda_i, i_scl};

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_ff  <= eep_pkg::eep_pins_s'(eep_pkg::PINS_IDLE);
            syn_a_ff <= eep_pkg::eep_pins_s'(eep_pkg::PINS_IDLE);
            syn_b_ff <= eep_pkg::eep_pins_s'(eep_pkg::PINS_IDLE);
            pins_ff  <= eep_pkg::eep_pins_s'(eep_pkg::PINS_IDLE);
        end
        else if (i_ce)
        begin
            meta_ff  <= pins_in;
            syn_a_ff <= meta_ff;
            syn_b_ff <= syn_a_ff;
            pins_ff  <= nxt_pins;
        end
    end

    always_comb
    begin
        nxt_pins = eep_pkg::eep_pins_s'(
            (~(syn_a_ff ^ syn_b_ff) & syn_b_ff)
            | ((syn_a_ff ^ syn_b_ff) & pins_ff));
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = ~pins_ff.scl & nxt_pins.scl;
    assign scl_fall  = pins_ff.scl & ~nxt_pins.scl;
    assign bus_start = pins_ff.scl & nxt_pins.scl
                       & pins_ff.sda & ~nxt_pins.sda;
    assign bus_stop  = pins_ff.scl & nxt_pins.scl
                       & ~pins_ff.sda & nxt_pins.sda;

    eep_pkg::eep_state_e state_ff;
    logic [3:0]          cnt_ff;
    logic                ack_pend_ff;
    logic                protect_ff;
    logic                slot_ff;
    logic [7:0]          addr_hi_ff;
    logic [MEM_AW-1:0]   addr_ff;
    logic [7:0]          out_ff;
    logic [7:0]          row_buf_ff [eep_pkg::ROW_BYTES];
    logic [31:0]         valid_ff;
    logic [TW-1:0]       timer_ff;
    logic [7:0]          rdata;
    eep_pkg::eep_wr_s    wr;

    logic byte_done;
    logic ack_rise;
    logic dev_hit;
    logic prog_go;
    logic mst_ack;

    // link byte is read only after the synchronised rise, by which
    // time it has been stable for at least two reference cycles
    assign byte_done = scl_rise && cnt_ff == eep_pkg::CNT_LAST
                       && state_ff != eep_pkg::ST_PROG;
    assign ack_rise  = scl_rise && cnt_ff == eep_pkg::CNT_ACK
                       && state_ff != eep_pkg::ST_PROG;
    assign dev_hit   = link_shift_ff[7:4] == P_DEV_TYPE
                       && link_shift_ff[3:1] == pins_ff.cs;
    // programming needs stop in the slot after an acked data byte
    assign prog_go   = bus_stop && slot_ff
                       && state_ff == eep_pkg::ST_WDAT
                       && |valid_ff;
    assign mst_ack   = ~nxt_pins.sda;

    // bit counter: 0..7 data bits, 8 is the ack clock
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cnt_ff <= eep_pkg::CNT_RST;
        else if (i_ce)
        begin
            if (bus_start)
                cnt_ff <= eep_pkg::CNT_RST;
            else if (scl_rise)
                cnt_ff <= (cnt_ff == eep_pkg::CNT_ACK)
                          ? eep_pkg::CNT_RST : 4'(cnt_ff + 1'b1);
        end
    end

    // command sequencing
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_ff    <= eep_pkg::ST_IDLE;
            ack_pend_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            if (state_ff == eep_pkg::ST_PROG)
            begin
                // start and select are not seen at all here
                if (timer_ff == TIMER_LAST)
                    state_ff <= eep_pkg::ST_IDLE;
            end
            else if (bus_start)
            begin
                // repeated start keeps the counter: random read
                state_ff    <= eep_pkg::ST_DEV;
                ack_pend_ff <= 1'b0;
            end
            else if (bus_stop)
                state_ff <= prog_go ? eep_pkg::ST_PROG
                                    : eep_pkg::ST_IDLE;
            else if (byte_done)
            begin
                case (state_ff)
                    eep_pkg::ST_DEV:
                    begin
                        ack_pend_ff <= dev_hit;
                        if (!dev_hit)
                            state_ff <= eep_pkg::ST_IDLE;
                        else if (link_shift_ff[0])
                            state_ff <= eep_pkg::ST_RDAT;
                        else
                            state_ff <= eep_pkg::ST_AHI;
                    end
                    eep_pkg::ST_AHI:
                    begin
                        ack_pend_ff <= 1'b1;
                        state_ff    <= eep_pkg::ST_ALO;
                    end
                    eep_pkg::ST_ALO:
                    begin
                        ack_pend_ff <= 1'b1;
                        state_ff    <= eep_pkg::ST_WDAT;
                    end
                    eep_pkg::ST_WDAT:
                        ack_pend_ff <= ~protect_ff;
                    default:
                        ack_pend_ff <= 1'b0;
                endcase
            end
            else if (ack_rise && state_ff == eep_pkg::ST_RDAT
                     && !ack_pend_ff && !mst_ack)
                state_ff <= eep_pkg::ST_IDLE;
        end
    end

    a_nack_idle: assert property (i_ce && ack_rise && !mst_ack
        && state_ff == eep_pkg::ST_RDAT && !ack_pend_ff && !bus_stop
        |=> state_ff == eep_pkg::ST_IDLE)
        else $error("read did not stop on master nack");

    a_hdr_ack_wp: assert property (i_ce && byte_done && protect_ff
        && state_ff == eep_pkg::ST_AHI |=> ack_pend_ff ##1 ack_pend_ff)
        else $error("address byte not acked under protect");

    // address counter
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            addr_hi_ff <= 8'h00;
            addr_ff    <= '0;
            out_ff     <= eep_pkg::ERASED;
        end
        else if (i_ce && state_ff != eep_pkg::ST_PROG)
        begin
            if (byte_done && state_ff == eep_pkg::ST_AHI)
                addr_hi_ff <= link_shift_ff;
            else if (byte_done && state_ff == eep_pkg::ST_ALO)
                addr_ff <= MEM_AW'({addr_hi_ff, link_shift_ff});
            else if (byte_done && state_ff == eep_pkg::ST_WDAT
                     && !protect_ff)
                addr_ff <= row_inc(addr_ff);
            else if ((byte_done && state_ff == eep_pkg::ST_DEV
                      && dev_hit && link_shift_ff[0])
                     || (ack_rise && state_ff == eep_pkg::ST_RDAT
                         && !ack_pend_ff && mst_ack))
            begin
                out_ff  <= rdata;
                addr_ff <= MEM_AW'(addr_ff + 1'b1);
            end
        end
    end

    a_row_wrap: assert property (i_ce && byte_done
        && state_ff == eep_pkg::ST_WDAT
        |=> $stable(addr_ff[MEM_AW-1:RB]))
        else $error("page write left its row");

    a_read_inc: assert property (i_ce && byte_done && dev_hit
        && state_ff == eep_pkg::ST_DEV && link_shift_ff[0]
        |=> addr_ff == MEM_AW'($past(addr_ff) + 1'b1))
        else $error("counter not advanced on read");

    // row buffer: nothing reaches the array until programming
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            valid_ff <= 32'h0000_0000;
            for (int i = 0; i < eep_pkg::ROW_BYTES; i++)
                row_buf_ff[i] <= eep_pkg::ERASED;
        end
        else if (i_ce)
        begin
            if (state_ff == eep_pkg::ST_PROG && timer_ff == TIMER_LAST)
                valid_ff <= 32'h0000_0000;
            else if (byte_done && state_ff == eep_pkg::ST_ALO)
                valid_ff <= 32'h0000_0000;
            else if (byte_done && state_ff == eep_pkg::ST_WDAT
                     && !protect_ff)
            begin
                row_buf_ff[addr_ff[RB-1:0]] <= link_shift_ff;
                valid_ff[addr_ff[RB-1:0]]   <= 1'b1;
            end
        end
    end

    // protect window runs from start to end of the low address byte
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            protect_ff <= 1'b0;
        else if (i_ce)
        begin
            if (bus_start && state_ff != eep_pkg::ST_PROG)
                protect_ff <= nxt_pins.wp;
            else if (pins_ff.wp && (state_ff == eep_pkg::ST_DEV
                     || state_ff == eep_pkg::ST_AHI
                     || state_ff == eep_pkg::ST_ALO))
                protect_ff <= 1'b1;
        end
    end

    a_wp_nack: assert property (i_ce && byte_done && protect_ff
        && state_ff == eep_pkg::ST_WDAT
        |=> !ack_pend_ff && valid_ff == $past(valid_ff))
        else $error("protected data byte accepted");

    // tenth slot: from the acked ack clock through the next high phase,
    // where the master's stop lands
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            slot_ff <= 1'b0;
        else if (i_ce)
        begin
            if (bus_start || bus_stop)
                slot_ff <= 1'b0;
            else if (ack_rise)
                slot_ff <= ack_pend_ff
                           && state_ff == eep_pkg::ST_WDAT;
            else if (scl_rise && cnt_ff != eep_pkg::CNT_RST)
                slot_ff <= 1'b0;
        end
    end

    a_prog_trigger: assert property (
        $rose(state_ff == eep_pkg::ST_PROG)
        |-> $past(slot_ff) && $past(bus_stop))
        else $error("programming started outside the stop slot");

    // program timer and commit walk over the row
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            timer_ff <= '0;
        else if (i_ce)
        begin
            if (state_ff != eep_pkg::ST_PROG)
                timer_ff <= '0;
            else
                timer_ff <= TW'(timer_ff + 1'b1);
        end
    end

    a_timer_bound: assert property (state_ff == eep_pkg::ST_PROG
        |-> timer_ff <= TIMER_LAST)
        else $error("program cycle overran its time");

    always_comb
    begin
        wr      = '0;
        wr.we   = state_ff == eep_pkg::ST_PROG && timer_ff < TIMER_ROW
                  && valid_ff[timer_ff[RB-1:0]];
        wr.addr[MEM_AW-1:0] = {addr_ff[MEM_AW-1:RB],
                               timer_ff[RB-1:0]};
        wr.data = row_buf_ff[timer_ff[RB-1:0]];
    end

    a_commit_prog: assert property (wr.we
        |-> state_ff == eep_pkg::ST_PROG && !protect_ff)
        else $error("array written outside a program cycle");

    eep_array #(
        .AW (MEM_AW)
    ) u_array (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_ce      (i_ce),
        .i_wr      (wr),
        .i_raddr   (16'(addr_ff)),
        .o_rdata   (rdata)
    );

    // data line: changes only on the low phase of the clock
    logic       sda_oe_ff;
    logic [2:0] bit_sel;

    assign bit_sel = 3'(eep_pkg::CNT_LAST - cnt_ff);

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            sda_oe_ff <= 1'b0;
        else if (i_ce)
        begin
            if (bus_start || bus_stop || state_ff == eep_pkg::ST_PROG)
                sda_oe_ff <= 1'b0;
            else if (scl_fall && cnt_ff == eep_pkg::CNT_ACK)
                sda_oe_ff <= ack_pend_ff;
            else if (scl_fall && state_ff == eep_pkg::ST_RDAT)
                sda_oe_ff <= ~out_ff[bit_sel];
            else if (scl_fall)
                sda_oe_ff <= 1'b0;
        end
    end

    a_prog_quiet: assert property (state_ff == eep_pkg::ST_PROG
        |=> !sda_oe_ff)
        else $error("line driven during programming");

    assign o_sda_o  = 1'b0;
    assign o_sda_oe = sda_oe_ff;
    assign o_busy   = state_ff == eep_pkg::ST_PROG;

endmodule
`default_nettype wire

/* File: bench/eep_master_model.sv */
/*
 * Behavioural two-wire bus master that faces the EEPROM slave.
 * Assumes a pull-up on the data line: the bench resolves the wire level.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_master_model (
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_pull
);
    localparam int T_LOW  = 44;
    localparam int T_HIGH = 21;
    logic lk;

    // own 30 ns tick, phase unrelated to the reference clock
    initial
    begin
        lk = 1'b0;
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
        #7;
        forever #15 lk = ~lk;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge lk);
    endtask

    // data moves only a few ticks after the clock fell: no false start
    task automatic bit_io(input logic b, output logic r);
        o_sda_pull = ~b;
        tk(T_LOW);
        o_scl = 1'b1;
        tk(T_HIGH);
        r = i_sda;
        o_scl = 1'b0;
        tk(4);
    endtask

    task automatic start();
        o_sda_pull = 1'b0;
        tk(T_LOW);
        o_scl = 1'b1;
        tk(T_HIGH);
        o_sda_pull = 1'b1;
        tk(T_HIGH);
        o_scl = 1'b0;
        tk(4);
    endtask

    // clock then stands still high until the next frame
    task automatic stop();
        o_sda_pull = 1'b1;
        tk(T_LOW);
        o_scl = 1'b1;
        tk(T_HIGH);
        o_sda_pull = 1'b0;
        tk(T_LOW);
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
endmodule
`default_nettype wire

/* File: bench/eep_i2c_slave_bench.sv */
/*
 * Self-checking bench for the EEPROM slave: writes, polling, reads.
 * Assumes the master model and the slave share one pulled-up data wire.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_i2c_slave_bench;
    localparam int PROG = 2000;
    localparam logic [6:0] SEL = {eep_pkg::DEV_TYPE, 3'h5};
    logic i_ref_clk, i_rst_b, wp, scl, pull, sda_oe, sda_o, busy, sda;
    int miscompares = 0, checks_done = 0, cyc = 0, run = 0, last_len = 0;
    logic [15:0] pa [4] = '{16'h1F3E, 16'h1F3F, 16'h1F20, 16'h1F21};
    logic [7:0]  pd [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

    assign sda = ~pull & (~sda_oe | sda_o);

    eep_i2c_slave #(.P_PROG_CYCLES(PROG)) eep_i2c_slave_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
        .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .i_write_protect_in(wp), .i_chip_select_pins(3'h5), .o_busy(busy));

    eep_master_model eep_master_model_inst (
        .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic conclude();
        $display("miscompares %0d checks_done %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // program time and a cycle ceiling, watched on every rising edge
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (busy === 1'b1)
            run++;
        else if (run != 0)
        begin
            last_len = run;
            run = 0;
        end
        if (cyc > 90000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic st();
        eep_master_model_inst.start();
    endtask

    task automatic sp();
        eep_master_model_inst.stop();
    endtask

    task automatic sb(input logic [7:0] d, input logic e);
        logic a;
        eep_master_model_inst.send(d, a);
        check({7'h00, a}, {7'h00, e});
    endtask

    task automatic addr(input logic [15:0] a);
        st();
        sb({SEL, 1'b0}, 1'b1);
        sb(a[15:8], 1'b1);
        sb(a[7:0], 1'b1);
    endtask

    task automatic cur(input logic [7:0] e);
        logic [7:0] d;
        st();
        sb({SEL, 1'b1}, 1'b1);
        eep_master_model_inst.recv(1'b0, d);
        sp();
        check(d, e);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        addr(a);
        cur(e);
    endtask

    // retry select until the end of programming shows as an acknowledge
    task automatic wait_ready();
        logic a;
        logic len_ok;
        a = 1'b0;
        for (int n = 0; n < 20 && !a; n++)
        begin
            st();
            eep_master_model_inst.send({SEL, 1'b0}, a);
        end
        check({7'h00, a}, 8'h01);
        len_ok = last_len >= PROG && last_len <= PROG + 40;
        check({7'h00, len_ok}, 8'h01);
    endtask

    initial
    begin
        i_rst_b = 1'b0;
        wp = 1'b0;
        repeat (4) @(posedge i_ref_clk);
        #1 i_rst_b = 1'b1;
        check({5'h00, sda_o, busy, sda_oe}, 8'h00);
        repeat (4) @(posedge i_ref_clk);
        rd(16'h0123, 8'hFF);
        cur(8'hFF);
        check({7'h00, sda_oe}, 8'h00);
        st();
        sb({4'h3, 3'h5, 1'b0}, 1'b0);
        st();
        sb({eep_pkg::DEV_TYPE, 3'h2, 1'b0}, 1'b0);
        sp();
        addr(16'h0040);
        sb(8'h5A, 1'b1);
        sp();
        check({7'h00, busy}, 8'h01);
        st();
        sb({SEL, 1'b0}, 1'b0);
        wait_ready();
        sb(8'h00, 1'b1);
        sb(8'h40, 1'b1);
        cur(8'h5A);
        // page crosses the row end: low five bits wrap; top bits ignored
        addr(16'hFF3E);
        for (int i = 0; i < 4; i++) sb(pd[i], 1'b1);
        sp();
        wait_ready();
        sp();
        for (int i = 0; i < 4; i++) rd(pa[i], pd[i]);
        // written neighbours tell an advanced counter from a stuck one
        rd(pa[0], pd[0]);
        cur(pd[1]);
        // protect seen only during the high address byte still blocks
        st();
        sb({SEL, 1'b0}, 1'b1);
        @(posedge i_ref_clk) #1 wp = 1'b1;
        sb(8'h00, 1'b1);
        @(posedge i_ref_clk) #1 wp = 1'b0;
        sb(8'h40, 1'b1);
        sb(8'h11, 1'b0);
        sp();
        check({7'h00, busy}, 8'h00);
        rd(16'h0040, 8'h5A);
        // stop away from the data slot drops the buffered byte
        addr(16'h0040);
        sb(8'h22, 1'b1);
        st();
        sp();
        check({7'h00, busy}, 8'h00);
        rd(16'h0040, 8'h5A);
        conclude();
    end
endmodule
`default_nettype wire
